// ---- hdl/pmicpr_pkg.sv ----
// Constants, types and register map of the power ack and reset control.
// Assumes a 100 MHz system clock and a 32-bit APB master.
package pmicpr_pkg;
   // ---------------------------------------------
   // Timing
   // ---------------------------------------------
   localparam int CLK_HZ = 100000000; // System clock rate
   localparam int TICK_MS = 1; // Slow tick period
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int WINDOW_S = 8; // Fixed active window
   localparam int WINDOW_TICKS = WINDOW_S * 1000 / TICK_MS;
   localparam int DEB_MS = 1; // Switch-off debounce
   localparam int DEB_CYCLES = CLK_HZ / 1000 * DEB_MS;
   localparam int MASK_MS = 25; // Switch-off mask after OFF
   localparam int MASK_TICKS = MASK_MS / TICK_MS;
   // ---------------------------------------------
   // Register offsets (byte addresses)
   // ---------------------------------------------
   localparam logic [7:0] A_DEVCTL = 8'h00; // device_control_reg
   localparam logic [7:0] A_CFG = 8'h04;
   localparam logic [7:0] A_LVLCFG = 8'h08; // off_request_level_config
   localparam logic [7:0] A_INTMSK = 8'h0C;
   localparam logic [7:0] A_INTSTA = 8'h10;
   localparam logic [7:0] A_CAUSE = 8'h14;
   localparam logic [7:0] A_BOOT = 8'h18;
   localparam logic [7:0] A_WARMSEL = 8'h1C;
   localparam logic [7:0] A_STATE = 8'h20;
   // ---------------------------------------------
   // Fields and reset values
   // ---------------------------------------------
   localparam int CFG_KEEPMODE = 0; // 1: auto_keep_on_mode family
   localparam int CFG_AUTOSET = 1; // Set keep_on_bit at sequence end
   localparam int CFG_MSLEEP = 2; // Mask interrupt in SLEEP
   localparam int CFG_SWPOL = 3; // Switch-off input active low
   localparam int CFG_COLD = 4; // Switch-off event restarts
   localparam logic [4:0] CFG_RST = 5'h06;
   localparam logic [3:0] LVL_RST = 4'hF;
   localparam logic [7:0] INTMSK_RST = 8'h00;
   localparam logic [7:0] WARMSEL_RST = 8'h00;
   localparam int CAU_HOLD = 0;
   localparam int CAU_WIN = 1;
   localparam int CAU_KEEP = 2;
   localparam int CAU_SWOFF = 3;
   localparam logic [7:0] REG0_BASE = 8'h00;
   localparam logic [7:0] REG0_LAST = 8'h2F;
   localparam logic [7:0] REG1_BASE = 8'h30;
   localparam logic [7:0] REG1_LAST = 8'h5F;
   // ---------------------------------------------
   // Stored sequences: two sets of four steps
   // ---------------------------------------------
   localparam int SEQ_STEPS = 4;
   localparam int RES_N = 8;
   // Resource index per [set][step]
   localparam logic [1:0][3:0][2:0] SEQ_RES = 24'hAC2842;
   // Delay in ticks after each step
   localparam logic [1:0][3:0][3:0] SEQ_DLY = 32'h21211212;
   // ---------------------------------------------
   // Types
   // ---------------------------------------------
   typedef enum logic [2:0] {ST_OFF, ST_UP, ST_ACTIVE, ST_SLEEP, ST_DOWN} pmicpr_state_t;
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pmicpr_apb_req_t;
   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } pmicpr_apb_rsp_t;
endpackage

// ---- hdl/pmicpr_top.sv ----
// Power-on acknowledge, sequencing and reset-domain control.
// Assumes pins arrive asynchronously and APB runs on i_clock.
//
// Notes on behaviour
// - ON request powers up; reset out in ACTIVE
// - Hold mode: 8 s window, then off if pin low
// - Hold pin falling edge means OFF
// - Auto mode sets keep_on bit at end
// - Non-auto mode watches keep_on bit instead
// - Boot pin chooses region and sequence set
// - Boot level latched after OFF-to-ACTIVE
// - Live boot pin level steers sequence branches
// - Global reset clears all three domains
// - Power-on domain survives other resets
// - Hardware-level OFF runs down sequence
// - Hardware reset clears hw and swo
// - Switch-off level clears swo domain only
// - Interrupt output push-pull, active low
// - Interrupt masked in SLEEP, per-source masks
// - Warm pin reruns up sequence to ACTIVE
// - Warm reset spares resources outside sequence
// - Warm reset reloads or keeps per bit
// - Switch-off input debounced 1 ms
// - Switch-off ignored 25 ms after OFF
// - Reset out released after sequence completes
// - Steps spaced by programmed delays
`timescale 1ns/1ps
module pmicpr_top #(
   parameter int P_TICK_CYCLES = pmicpr_pkg::TICK_CYCLES,
   parameter int P_DEB_CYCLES = pmicpr_pkg::DEB_CYCLES,
   parameter int P_WINDOW_TICKS = pmicpr_pkg::WINDOW_TICKS,
   parameter int P_MASK_TICKS = pmicpr_pkg::MASK_TICKS
) (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire pmicpr_pkg::pmicpr_apb_req_t i_apb,
   output pmicpr_pkg::pmicpr_apb_rsp_t o_apb,
   input wire logic i_on_req,
   input wire logic i_hold_on_pin,
   input wire logic i_boot_pin,
   input wire logic i_warm_restart_n,
   input wire logic i_switchoff_in,
   input wire logic i_sleep_req,
   input wire logic [7:0] i_irq_src,
   output logic o_reset_out,
   output logic o_int_n,
   output logic [7:0] o_res_en,
   output logic [7:0] o_res_reload
);
   // ---------------------------------------------
   // Elaboration checks
   // ---------------------------------------------
   if (P_TICK_CYCLES < 2 || P_TICK_CYCLES > 131072) begin : g_bad_tick
      $error("tick divider out of range");
   end
   if (P_DEB_CYCLES < 1 || P_DEB_CYCLES > 131072) begin : g_bad_deb
      $error("debounce count out of range");
   end
   if (P_WINDOW_TICKS < 1 || P_WINDOW_TICKS > 8191) begin : g_bad_win
      $error("window count out of range");
   end
   if (P_MASK_TICKS < 1 || P_MASK_TICKS > 31) begin : g_bad_mask
      $error("mask count out of range");
   end

   // Synchroniser bit positions
   localparam int SY_ON = 0;
   localparam int SY_HOLD = 1;
   localparam int SY_BOOT = 2;
   localparam int SY_WARM = 3;
   localparam int SY_SWOFF = 4;
   localparam int SY_SLEEP = 5;
   // Counter end and load values at counter width
   localparam logic [16:0] TICK_LAST = 17'(P_TICK_CYCLES - 1);
   localparam logic [16:0] DEB_LAST = 17'(P_DEB_CYCLES - 1);
   localparam logic [12:0] WIN_LOAD = 13'(P_WINDOW_TICKS);
   localparam logic [4:0] MASK_LOAD = 5'(P_MASK_TICKS);

   // ---------------------------------------------
   // State of the whole block
   // ---------------------------------------------
   typedef struct packed {
      logic [5:0] sync1; // First stage, read by sync2 only
      logic [5:0] sync2; // Settled pin levels
      logic on_d; // Edge detect history
      logic hold_d;
      logic warm_d;
      logic keep_d;
      pmicpr_pkg::pmicpr_state_t state;
      logic [16:0] tick_cnt; // Slow tick divider
      logic [16:0] deb_cnt; // Switch-off debounce
      logic deb_lvl; // Debounced switch-off level
      logic [12:0] win_cnt; // Active window
      logic win_on;
      logic [4:0] mask_cnt; // Post-OFF mask
      logic [1:0] step; // Sequence step
      logic [3:0] dly; // Ticks left before next step
      logic warm_run; // Up sequence is a warm reset
      logic lvl_hw; // Pending reset is hardware level
      logic [7:0] res_en;
      logic [7:0] reload;
      logic reset_out;
      logic int_n;
      logic keep_on; // Switch-off domain
      logic [7:0] warmsel; // Switch-off domain
      logic [4:0] cfg; // Hardware domain
      logic [3:0] lvlcfg; // Hardware domain
      logic [7:0] intmsk; // Hardware domain
      logic [3:0] cause; // Power-on domain
      logic boot_lvl; // Power-on domain
      logic rdy;
      logic [31:0] rdata;
      logic err;
   } pmicpr_st_t;

   pmicpr_st_t r_ff;
   pmicpr_st_t nxt_r;

   // ---------------------------------------------
   // Derived conditions
   // ---------------------------------------------
   logic tick; // One-cycle slow tick
   logic sw_raw; // Switch-off level after polarity
   logic sw_ev; // Debounced switch-off assertion
   logic hold_mode;
   logic hold_fall;
   logic keep_fall;
   logic watched; // Level that keeps the device on
   logic win_exp;
   logic [3:0] off_cause;
   logic off_req;
   logic warm_fall;
   logic on_rise;
   logic set_sel; // Sequence set from boot pin
   logic [2:0] cur_res;
   logic [3:0] cur_dly;
   logic irq_pend;
   logic awake; // ACTIVE or SLEEP
   logic acc; // APB access phase, first cycle
   logic fin; // APB access completes this edge
   logic wr; // Write takes effect this edge
   logic [31:0] rd; // Read mux
   logic hit; // Address maps to a register

   assign tick = r_ff.tick_cnt == TICK_LAST;
   assign sw_raw = r_ff.sync2[SY_SWOFF] ^ r_ff.cfg[pmicpr_pkg::CFG_SWPOL];
   // Stable for the full debounce at either polarity
   assign sw_ev = sw_raw && !r_ff.deb_lvl && r_ff.deb_cnt == DEB_LAST;
   assign hold_mode = !r_ff.cfg[pmicpr_pkg::CFG_KEEPMODE];
   assign awake = r_ff.state == pmicpr_pkg::ST_ACTIVE || r_ff.state == pmicpr_pkg::ST_SLEEP;
   assign hold_fall = hold_mode && r_ff.hold_d && !r_ff.sync2[SY_HOLD];
   assign keep_fall = !hold_mode && r_ff.keep_d && !r_ff.keep_on;
   // Window watches the pin, or the bit when not auto-set
   assign watched = hold_mode ? r_ff.sync2[SY_HOLD] : r_ff.keep_on;
   assign win_exp = r_ff.win_on && r_ff.win_cnt == 13'h0000 && !watched;
   assign off_cause = {sw_ev, keep_fall, win_exp, hold_fall};
   assign off_req = awake && |off_cause;
   assign warm_fall = r_ff.warm_d && !r_ff.sync2[SY_WARM];
   assign on_rise = !r_ff.on_d && r_ff.sync2[SY_ON];
   // Live pin level branches the running sequence
   assign set_sel = r_ff.sync2[SY_BOOT];
   assign cur_res = pmicpr_pkg::SEQ_RES[set_sel][r_ff.step];
   assign cur_dly = pmicpr_pkg::SEQ_DLY[set_sel][r_ff.step];
   assign irq_pend = |(i_irq_src & ~r_ff.intmsk);
   assign acc = i_apb.psel && i_apb.penable && !r_ff.rdy;
   assign fin = i_apb.psel && i_apb.penable && r_ff.rdy;
   assign wr = fin && i_apb.pwrite && !r_ff.err;

   // ---------------------------------------------
   // Register read decode
   // ---------------------------------------------
   always_comb begin
      rd = 32'h00000000;
      hit = 1'b1;
      unique case (i_apb.paddr)
         pmicpr_pkg::A_DEVCTL: rd[0] = r_ff.keep_on;
         pmicpr_pkg::A_CFG: rd[4:0] = r_ff.cfg;
         pmicpr_pkg::A_LVLCFG: rd[3:0] = r_ff.lvlcfg;
         pmicpr_pkg::A_INTMSK: rd[7:0] = r_ff.intmsk;
         pmicpr_pkg::A_INTSTA: rd[15:0] = {i_irq_src, i_irq_src & ~r_ff.intmsk};
         pmicpr_pkg::A_CAUSE: rd[3:0] = r_ff.cause;
         pmicpr_pkg::A_BOOT: begin
            // Latched level and its stored region bounds
            rd[0] = r_ff.boot_lvl;
            rd[15:8] = r_ff.boot_lvl ? pmicpr_pkg::REG1_BASE : pmicpr_pkg::REG0_BASE;
            rd[23:16] = r_ff.boot_lvl ? pmicpr_pkg::REG1_LAST : pmicpr_pkg::REG0_LAST;
         end
         pmicpr_pkg::A_WARMSEL: rd[7:0] = r_ff.warmsel;
         pmicpr_pkg::A_STATE: rd[11:0] = {r_ff.res_en, r_ff.reset_out, r_ff.state};
         default: hit = 1'b0; // Unmapped: error answer
      endcase
   end

   // ---------------------------------------------
   // Next state
   // ---------------------------------------------
   always_comb begin
      nxt_r = r_ff;
      // Two-stage pin synchronisers
      nxt_r.sync1 = {i_sleep_req, i_switchoff_in, i_warm_restart_n, i_boot_pin, i_hold_on_pin, i_on_req};
      nxt_r.sync2 = r_ff.sync1;
      nxt_r.on_d = r_ff.sync2[SY_ON];
      nxt_r.hold_d = r_ff.sync2[SY_HOLD];
      nxt_r.warm_d = r_ff.sync2[SY_WARM];
      nxt_r.keep_d = r_ff.keep_on;
      nxt_r.reload = 8'h00;
      nxt_r.tick_cnt = tick ? 17'h00000 : r_ff.tick_cnt + 17'h00001;

      // Debounce restarts whenever the level moves back
      if (sw_raw != r_ff.deb_lvl) begin
         if (r_ff.deb_cnt == DEB_LAST) begin
            nxt_r.deb_lvl = sw_raw;
            nxt_r.deb_cnt = 17'h00000;
         end else begin
            nxt_r.deb_cnt = r_ff.deb_cnt + 17'h00001;
         end
      end else begin
         nxt_r.deb_cnt = 17'h00000;
      end

      // APB: one wait state so read data comes from flops
      if (acc) begin
         nxt_r.rdy = 1'b1;
         nxt_r.rdata = i_apb.pwrite ? 32'h00000000 : rd;
         nxt_r.err = !hit;
      end
      if (fin) begin
         nxt_r.rdy = 1'b0;
      end
      if (wr) begin
         unique case (i_apb.paddr)
            pmicpr_pkg::A_DEVCTL: nxt_r.keep_on = i_apb.pwdata[0];
            pmicpr_pkg::A_CFG: nxt_r.cfg = i_apb.pwdata[4:0];
            pmicpr_pkg::A_LVLCFG: nxt_r.lvlcfg = i_apb.pwdata[3:0];
            pmicpr_pkg::A_INTMSK: nxt_r.intmsk = i_apb.pwdata[7:0];
            pmicpr_pkg::A_CAUSE: nxt_r.cause = r_ff.cause & ~i_apb.pwdata[3:0];
            pmicpr_pkg::A_WARMSEL: nxt_r.warmsel = i_apb.pwdata[7:0];
            default: ;
         endcase
      end

      // Window counts down on slow ticks
      if (awake && r_ff.win_on) begin
         if (r_ff.win_cnt == 13'h0000) begin
            nxt_r.win_on = 1'b0;
         end else if (tick) begin
            nxt_r.win_cnt = r_ff.win_cnt - 13'h0001;
         end
      end

      // Sequencer
      unique case (r_ff.state)
         pmicpr_pkg::ST_OFF: begin
            nxt_r.reset_out = 1'b0;
            // Switch-off events ignored while masked
            if (r_ff.mask_cnt != 5'h00) begin
               if (tick) begin
                  nxt_r.mask_cnt = r_ff.mask_cnt - 5'h01;
               end
            end
            if (on_rise || (sw_ev && r_ff.mask_cnt == 5'h00 && r_ff.cfg[pmicpr_pkg::CFG_COLD])) begin
               nxt_r.state = pmicpr_pkg::ST_UP;
               nxt_r.step = 2'h0;
               nxt_r.dly = 4'h0;
               nxt_r.warm_run = 1'b0;
            end
         end
         pmicpr_pkg::ST_UP: begin
            nxt_r.reset_out = 1'b0;
            if (r_ff.dly != 4'h0) begin
               if (tick) begin
                  nxt_r.dly = r_ff.dly - 4'h1;
               end
            end else begin
               nxt_r.res_en[cur_res] = 1'b1;
               // Restart the tick so each step gap is whole ticks
               nxt_r.tick_cnt = 17'h00000;
               // Warm reset: reload stored level unless kept
               if (r_ff.warm_run && !r_ff.warmsel[cur_res]) begin
                  nxt_r.reload[cur_res] = 1'b1;
               end
               if (r_ff.step == 2'(pmicpr_pkg::SEQ_STEPS - 1)) begin
                  // Sequence done: release reset
                  nxt_r.state = pmicpr_pkg::ST_ACTIVE;
                  nxt_r.reset_out = 1'b1;
                  nxt_r.win_cnt = WIN_LOAD;
                  nxt_r.win_on = hold_mode || !r_ff.cfg[pmicpr_pkg::CFG_AUTOSET];
                  if (!hold_mode && r_ff.cfg[pmicpr_pkg::CFG_AUTOSET]) begin
                     nxt_r.keep_on = 1'b1;
                  end
                  if (!r_ff.warm_run) begin
                     nxt_r.boot_lvl = r_ff.sync2[SY_BOOT];
                  end
               end else begin
                  nxt_r.step = r_ff.step + 2'h1;
                  nxt_r.dly = cur_dly;
               end
            end
         end
         pmicpr_pkg::ST_ACTIVE: begin
            if (r_ff.sync2[SY_SLEEP]) begin
               nxt_r.state = pmicpr_pkg::ST_SLEEP;
            end
         end
         pmicpr_pkg::ST_SLEEP: begin
            if (!r_ff.sync2[SY_SLEEP]) begin
               nxt_r.state = pmicpr_pkg::ST_ACTIVE;
            end
         end
         pmicpr_pkg::ST_DOWN: begin
            nxt_r.reset_out = 1'b0;
            if (r_ff.dly != 4'h0) begin
               if (tick) begin
                  nxt_r.dly = r_ff.dly - 4'h1;
               end
            end else begin
               // Reverse order of the up sequence
               nxt_r.res_en[cur_res] = 1'b0;
               // Same restart on the way down
               nxt_r.tick_cnt = 17'h00000;
               if (r_ff.step == 2'h0) begin
                  nxt_r.state = pmicpr_pkg::ST_OFF;
                  nxt_r.mask_cnt = MASK_LOAD;
                  nxt_r.win_on = 1'b0;
                  // Switch-off domain always cleared
                  nxt_r.keep_on = 1'b0;
                  nxt_r.warmsel = pmicpr_pkg::WARMSEL_RST;
                  if (r_ff.lvl_hw) begin
                     // Hardware domain too; power-on domain kept
                     nxt_r.cfg = pmicpr_pkg::CFG_RST;
                     nxt_r.lvlcfg = pmicpr_pkg::LVL_RST;
                     nxt_r.intmsk = pmicpr_pkg::INTMSK_RST;
                  end
               end else begin
                  nxt_r.step = r_ff.step - 2'h1;
                  nxt_r.dly = pmicpr_pkg::SEQ_DLY[set_sel][r_ff.step - 2'h1];
               end
            end
         end
      endcase

      // OFF request outranks warm reset and sleep moves
      if (off_req) begin
         nxt_r.state = pmicpr_pkg::ST_DOWN;
         nxt_r.reset_out = 1'b0;
         nxt_r.step = 2'(pmicpr_pkg::SEQ_STEPS - 1);
         nxt_r.dly = 4'h0;
         nxt_r.lvl_hw = |(off_cause & r_ff.lvlcfg);
      end else if (awake && warm_fall) begin
         // Only sequence resources are touched
         nxt_r.state = pmicpr_pkg::ST_UP;
         nxt_r.reset_out = 1'b0;
         nxt_r.step = 2'h0;
         nxt_r.dly = 4'h0;
         nxt_r.warm_run = 1'b1;
      end
      // Cause capture: a new event wins over a clear
      if (awake) begin
         nxt_r.cause = nxt_r.cause | off_cause;
      end

      // Push-pull interrupt, low while pending
      nxt_r.int_n = !(irq_pend && !(r_ff.state == pmicpr_pkg::ST_SLEEP
                      && r_ff.cfg[pmicpr_pkg::CFG_MSLEEP]));
   end

   // ---------------------------------------------
   // State register
   // ---------------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         // Global reset clears every domain
         r_ff <= '0;
         r_ff.state <= pmicpr_pkg::ST_OFF;
         r_ff.sync1 <= 6'h08;
         r_ff.sync2 <= 6'h08;
         r_ff.warm_d <= 1'b1;
         r_ff.int_n <= 1'b1;
         r_ff.cfg <= pmicpr_pkg::CFG_RST;
         r_ff.lvlcfg <= pmicpr_pkg::LVL_RST;
         r_ff.intmsk <= pmicpr_pkg::INTMSK_RST;
         r_ff.warmsel <= pmicpr_pkg::WARMSEL_RST;
      end else begin
         r_ff <= nxt_r;
      end
   end

   // ---------------------------------------------
   // Outputs
   // ---------------------------------------------
   assign o_apb.prdata = r_ff.rdata;
   assign o_apb.pready = r_ff.rdy;
   assign o_apb.pslverr = r_ff.rdy && r_ff.err;
   assign o_reset_out = r_ff.reset_out;
   assign o_int_n = r_ff.int_n;
   assign o_res_en = r_ff.res_en;
   assign o_res_reload = r_ff.reload;
endmodule

// ---- verification/pmic_power_ack_reset_control_test.sv ----
// Self-checking bench for the power ack and reset control block.
// Assumes short counts: tick 4 cycles, window 20 ticks, debounce 4.
`timescale 1ns/1ps
module pmic_power_ack_reset_control_test;
   logic clk, rst, on, warm_n, swoff, keep, boot_sel, hold, boot, rout, int_n, slp;
   logic [7:0] irq, res_en, reload, acc;
   pmicpr_pkg::pmicpr_apb_req_t req;
   pmicpr_pkg::pmicpr_apb_rsp_t rsp;
   int n_mismatch, checks_done, n;
   pmicpr_top #(.P_TICK_CYCLES(4), .P_DEB_CYCLES(4), .P_WINDOW_TICKS(20), .P_MASK_TICKS(3)) DUT (
      .i_clock(clk), .i_rst(rst), .i_apb(req), .o_apb(rsp), .i_on_req(on), .i_hold_on_pin(hold),
      .i_boot_pin(boot), .i_warm_restart_n(warm_n), .i_switchoff_in(swoff), .i_sleep_req(slp),
      .i_irq_src(irq), .o_reset_out(rout), .o_int_n(int_n), .o_res_en(res_en), .o_res_reload(reload));
   pmicpr_host u_host (.i_clock(clk), .i_rst(rst), .i_reset_out(rout), .i_keep(keep),
      .i_boot_sel(boot_sel), .o_hold_on_pin(hold), .o_boot_pin(boot));
   // ---------------------------------------------
   // Report and compare
   // ---------------------------------------------
   task automatic end_of_test();
      $display("Checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // ---------------------------------------------
   // APB master: setup, access held until pready
   // ---------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
      int k;
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk);
      req.penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (rsp.pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         n_mismatch++;
         end_of_test();
      end
      q = rsp.prdata;
      e = rsp.pslverr;
      // Idle edge so the next request never lands in this time step
      req <= '0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      cmp($sformatf("reg %h", a), exp, q);
   endtask
   // Bounded wait on the reset output, n holds the cycles taken
   task automatic wait_out(input logic lvl);
      int k;
      n = 0;
      k = 0;
      while (rout !== lvl && n < 400) begin
         @(posedge clk);
         n++;
      end
      // Going low also waits for the down sequence to reach OFF
      while (!lvl && res_en !== 8'h00 && k < 400) begin
         @(posedge clk);
         k++;
      end
      if (n >= 400 || k >= 400) begin
         n_mismatch++;
         end_of_test();
      end
   endtask
   task automatic power_on();
      on <= 1'b1;
      repeat (4) @(posedge clk);
      on <= 1'b0;
      wait_out(1'b1);
   endtask
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // ---------------------------------------------
   // Main sequence
   // ---------------------------------------------
   initial begin
      logic [31:0] q;
      logic e;
      rst = 1'b1; req = '0; on = 1'b0; warm_n = 1'b1; swoff = 1'b0; irq = 8'h00;
      keep = 1'b0; boot_sel = 1'b0; slp = 1'b0; n_mismatch = 0; checks_done = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rd(pmicpr_pkg::A_CFG, 32'h00000006);
      rd(pmicpr_pkg::A_LVLCFG, 32'h0000000F);
      rd(pmicpr_pkg::A_STATE, 32'h00000000);
      apb(1'b0, 8'h40, 32'h0, q, e);
      cmp("unmapped error", 32'h1, {31'h0, e});
      // Hold mode, set 0, host keeps the pin up past the window
      wr(pmicpr_pkg::A_CFG, 32'h00000000);
      keep <= 1'b1;
      power_on();
      rd(pmicpr_pkg::A_STATE, {20'h0, 8'h17, 1'b1, 3'h2});
      rd(pmicpr_pkg::A_BOOT, 32'h002F0000);
      repeat (120) @(posedge clk);
      cmp("held on", 32'h1, {31'h0, rout});
      keep <= 1'b0;
      wait_out(1'b0);
      rd(pmicpr_pkg::A_CAUSE, 32'h00000001);
      rd(pmicpr_pkg::A_CFG, 32'h00000006);
      // Hold mode, set 1, pin never raised, switch-off level
      wr(pmicpr_pkg::A_LVLCFG, 32'h00000000);
      wr(pmicpr_pkg::A_CFG, 32'h00000000);
      boot_sel <= 1'b1;
      power_on();
      rd(pmicpr_pkg::A_BOOT, 32'h005F3001);
      wr(pmicpr_pkg::A_WARMSEL, 32'h00000001);
      wait_out(1'b0);
      cmp("window end", 32'h1, {31'h0, n > 60 && n < 140});
      rd(pmicpr_pkg::A_CAUSE, 32'h00000003);
      rd(pmicpr_pkg::A_CFG, 32'h00000000);
      rd(pmicpr_pkg::A_WARMSEL, 32'h00000000);
      // Auto keep-on mode, interrupt masked in sleep, glitch, warm reset
      wr(pmicpr_pkg::A_LVLCFG, 32'h0000000F);
      wr(pmicpr_pkg::A_CFG, 32'h00000007);
      boot_sel <= 1'b0;
      power_on();
      rd(pmicpr_pkg::A_DEVCTL, 32'h00000001);
      irq <= 8'h01;
      repeat (4) @(posedge clk);
      cmp("int pending", 32'h0, {31'h0, int_n});
      slp <= 1'b1;
      repeat (6) @(posedge clk);
      cmp("int in sleep", 32'h1, {31'h0, int_n});
      slp <= 1'b0;
      repeat (6) @(posedge clk);
      wr(pmicpr_pkg::A_INTMSK, 32'h00000001);
      repeat (4) @(posedge clk);
      cmp("int masked", 32'h1, {31'h0, int_n});
      irq <= 8'h00;
      swoff <= 1'b1;
      repeat (2) @(posedge clk);
      swoff <= 1'b0;
      repeat (100) @(posedge clk);
      cmp("stays on", 32'h1, {31'h0, rout});
      warm_n <= 1'b0;
      acc = 8'h00;
      for (int i = 0; i < 150; i++) begin
         @(posedge clk);
         acc = acc | reload;
         if (i == 3) warm_n <= 1'b1;
      end
      cmp("reloaded", 32'h17, {24'h0, acc});
      rd(pmicpr_pkg::A_STATE, {20'h0, 8'h17, 1'b1, 3'h2});
      rd(pmicpr_pkg::A_INTMSK, 32'h00000001);
      wr(pmicpr_pkg::A_DEVCTL, 32'h00000000);
      wait_out(1'b0);
      rd(pmicpr_pkg::A_CAUSE, 32'h00000007);
      end_of_test();
   end
endmodule

// ---- verification/pmicpr_host.sv ----
// Host processor model: holds the hold pin and ties the boot pin.
// Assumes the bench tells it whether the host wants to stay on.
`timescale 1ns/1ps
module pmicpr_host (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_reset_out,
   input wire logic i_keep,
   input wire logic i_boot_sel,
   output logic o_hold_on_pin,
   output logic o_boot_pin
);
   logic [2:0] dly_ff; // Cycles since release, saturating
   // Board strap, never floating
   assign o_boot_pin = i_boot_sel;
   // Host answers well inside the window, and drops the pin when done
   always_ff @(posedge i_clock) begin
      if (i_rst) begin
         dly_ff <= 3'h0;
         o_hold_on_pin <= 1'b0;
      end else begin
         dly_ff <= !i_reset_out ? 3'h0 : (dly_ff == 3'h7 ? dly_ff : dly_ff + 3'h1);
         o_hold_on_pin <= i_keep && (dly_ff == 3'h7 || o_hold_on_pin);
      end
   end
endmodule

// ---- verification/pmicpr_sva.sv ----
// Port checker for the power ack and reset control block.
// Assumes it is bound to pmicpr_top and sees only that module's ports.
`timescale 1ns/1ps
module pmicpr_sva (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire pmicpr_pkg::pmicpr_apb_req_t i_apb,
   input wire pmicpr_pkg::pmicpr_apb_rsp_t o_apb,
   input wire logic o_reset_out,
   input wire logic o_int_n,
   input wire logic [7:0] o_res_en,
   input wire logic [7:0] o_res_reload
);
   // ---------------------------------------------
   // Clocking and bus phases
   // ---------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence s_setup; i_apb.psel && !i_apb.penable; endsequence
   sequence s_access; i_apb.psel && i_apb.penable; endsequence
   // ---------------------------------------------
   // Assertions
   // ---------------------------------------------
   // Global reset runs with no disable, it is the cause under test
   a_reset_clears_all: assert property (disable iff (1'b0) i_rst |=> !o_reset_out && o_int_n && o_res_en == 8'h00)
      else $error("outputs not cleared by global reset");
   a_apb_one_wait: assert property (s_setup ##1 s_access |=> o_apb.pready)
      else $error("bus answer not one cycle after access");
   a_pready_single: assert property (o_apb.pready |=> !o_apb.pready)
      else $error("bus answer stood more than one cycle");
   a_unmapped_err: assert property (o_apb.pready && i_apb.paddr > 8'h20 |-> o_apb.pslverr)
      else $error("unmapped access not refused");
   // Release only with a complete stored sequence in place
   a_release_full_set: assert property ($rose(o_reset_out) |-> o_res_en == 8'h17 || o_res_en == 8'h2D)
      else $error("reset released before sequence end");
   a_one_step_at_once: assert property ($changed(o_res_en) |-> $onehot(o_res_en ^ $past(o_res_en)))
      else $error("several resources switched together");
   a_step_gap_kept: assert property ($changed(o_res_en) && o_res_en > $past(o_res_en) |=> $stable(o_res_en) [*3])
      else $error("power-up steps closer than one tick");
   a_reload_single: assert property (o_res_reload != 8'h00 |=> (o_res_reload & $past(o_res_reload)) == 8'h00)
      else $error("reload pulse longer than one cycle");
   a_reload_in_seq: assert property (o_res_reload != 8'h00 |-> (o_res_reload & ~o_res_en) == 8'h00)
      else $error("reload on a resource outside the sequence");
endmodule

bind pmicpr_top pmicpr_sva u_sva (.i_clock(i_clock), .i_rst(i_rst), .i_apb(i_apb), .o_apb(o_apb),
   .o_reset_out(o_reset_out), .o_int_n(o_int_n), .o_res_en(o_res_en), .o_res_reload(o_res_reload));
